// ### core/amoc_core.sv
`timescale 1ns/10ps
// Contract
// - mode field decodes eight modes, continuous conversion after reset
// - continuous mode stores every result and pulls ready low
// - with continuous read set, each new result shifts out on serial clocks
// - without continuous read, a read request shifts out the result
// - first result after reset or reconfiguration waits full settling time
// - single conversion waits clock settle, then one full settling conversion
// - single conversion stores result, ready low, then powers down itself
// - single result and low ready kept until read or next conversion
// - idle holds filter and modulator in reset, modulator clock runs
// - power-down stops all but bridge switch and selected crystal
// - internal zero-scale shorts input, stores offset of selected channel
// - internal full-scale applies reference, stores full-scale coefficient
// - calibration drives ready high at start, low when finished
// - any finished calibration places the device in idle
// - system zero-scale measures selected pins, stores offset coefficient
// - system full-scale measures selected pins, stores full-scale coefficient
module amoc_core
   import amoc_pkg::*;
#(
   parameter logic [23:0] PWRUP_CYC = 24'(PWRUP_CYC_DEF)
)(
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [23:0]   sample_i,
   input  wire logic          sclk_i,
   output logic               dout_rdy_o,
   output logic               irq_o,
   output logic               filter_rst_o,
   output logic               mod_rst_o,
   output logic               mod_clk_en_o,
   output logic               analog_on_o,
   output logic               xtal_on_o,
   output logic               bridge_sw_o,
   output logic               in_short_o,
   output logic               in_fsref_o
);

   // ==========================================================
   // first set bit of the channel mask picks the coefficient slot
   function automatic logic [2:0] ch_index(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NCH - 1; i >= 0; i--)
      begin
         if (m[i])
            r = 3'(i);
      end
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction

   amoc_state_t  state_q;
   amoc_mode_t   mode_q;
   logic [23:0]  cnt_q;
   logic [23:0]  settle_q;
   logic [23:0]  period_q;
   logic [23:0]  data_q;
   logic [23:0]  offs_q [NCH];
   logic [23:0]  full_q [NCH];
   logic         continuous_read_enable_q;
   logic [7:0]   chan_q;
   logic         xtal_sel_q;
   logic         bridge_q;
   logic         rdy_n_q;
   logic [1:0]   irq_st_q;
   logic [1:0]   irq_en_q;
   logic         ack_q;
   logic [31:0]  rdat_q;
   logic         sclk_s1_q;
   logic         sclk_s2_q;
   logic         sclk_s3_q;
   logic [23:0]  sh_q;
   logic [4:0]   sh_cnt_q;
   logic         dout_q;

   // ==========================================================
   // bus strobes: a write takes effect on the edge that shows ack
   logic         acc;
   logic         wr;
   logic         rd;
   logic         wr_mode;
   logic         running;
   logic         tick;
   logic         conv_done;
   logic         cal_done;
   logic         shifting;
   logic         sclk_fall;
   logic         rd_req;
   logic         shift_end;
   logic [2:0]   ch;

   assign acc       = wb_cyc_i & wb_stb_i;
   assign wr        = acc & wb_we_i & ack_q;
   assign rd        = acc & ~wb_we_i & ack_q;
   assign wr_mode   = wr & wb_sel_i[0] & hit(wb_adr_i, ADR_MODE);
   assign running   = (state_q == ST_PWRUP) | (state_q == ST_SETTLE)
                    | (state_q == ST_CONV) | (state_q == ST_CAL);
   assign tick      = running & (cnt_q == 24'h00_0000);
   assign conv_done = tick & ~wr_mode
                    & ((state_q == ST_SETTLE) | (state_q == ST_CONV));
   assign cal_done  = tick & ~wr_mode & (state_q == ST_CAL);
   assign ch        = ch_index(chan_q);
   assign shifting  = sh_cnt_q != 5'h00;
   assign sclk_fall = sclk_s3_q & ~sclk_s2_q;
   assign rd_req    = wr & wb_sel_i[0] & hit(wb_adr_i, ADR_CMD)
                    & wb_dat_i[CMD_RDREQ];
   assign shift_end = shifting & sclk_fall & (sh_cnt_q == 5'h01);

   // ==========================================================
   // mode sequencer
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_q <= ST_SETTLE;
         mode_q  <= MODE_CONT;
         cnt_q   <= SETTLE_RST;
      end
      else if (wr_mode)
      begin
         mode_q <= amoc_mode_t'(wb_dat_i[2:0]);
         case (amoc_mode_t'(wb_dat_i[2:0]))
            MODE_CONT:
            begin
               state_q <= ST_SETTLE;
               cnt_q   <= settle_q;
            end
            MODE_SINGLE:
            begin
               state_q <= ST_PWRUP;
               cnt_q   <= PWRUP_CYC;
            end
            MODE_IDLE:  state_q <= ST_IDLE;
            MODE_PDOWN: state_q <= ST_PDOWN;
            default:
            begin
               state_q <= ST_CAL;
               cnt_q   <= settle_q;
            end
         endcase
      end
      else if (tick)
      begin
         case (state_q)
            ST_PWRUP:
            begin
               state_q <= ST_SETTLE;
               cnt_q   <= settle_q;
            end
            ST_SETTLE, ST_CONV:
            begin
               if (mode_q == MODE_SINGLE)
               begin
                  state_q <= ST_PDOWN;
                  mode_q  <= MODE_PDOWN;
               end
               else
               begin
                  state_q <= ST_CONV;
                  cnt_q   <= period_q;
               end
            end
            ST_CAL:
            begin
               state_q <= ST_IDLE;
               mode_q  <= MODE_IDLE;
            end
            default: state_q <= state_q;
         endcase
      end
      else if (running)
         cnt_q <= cnt_q - 24'h00_0001;
   end

   // ==========================================================
   // result and per-channel coefficients
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         data_q <= 24'h00_0000;
         for (int i = 0; i < NCH; i++)
         begin
            offs_q[i] <= 24'h00_0000;
            full_q[i] <= 24'h00_0000;
         end
      end
      else if (conv_done)
         data_q <= sample_i;
      else if (cal_done)
      begin
         if (mode_q[0] == 1'b0)
            offs_q[ch] <= sample_i;
         else
            full_q[ch] <= sample_i;
      end
   end

   // ==========================================================
   // ready: a new result beats a read in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rdy_n_q <= 1'b1;
      else if (conv_done | cal_done)
         rdy_n_q <= 1'b0;
      else if (wr_mode & wb_dat_i[2])
         rdy_n_q <= 1'b1;
      else if (shift_end | (rd & hit(wb_adr_i, ADR_DATA)))
         rdy_n_q <= 1'b1;
   end

   // ==========================================================
   // analog steering, registered from the sequencer state
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         filter_rst_o <= 1'b1;
         mod_rst_o    <= 1'b1;
         mod_clk_en_o <= 1'b1;
         analog_on_o  <= 1'b1;
         xtal_on_o    <= 1'b1;
         bridge_sw_o  <= 1'b0;
         in_short_o   <= 1'b0;
         in_fsref_o   <= 1'b0;
      end
      else
      begin
         filter_rst_o <= state_q inside {ST_IDLE, ST_PDOWN, ST_PWRUP};
         mod_rst_o    <= state_q inside {ST_IDLE, ST_PDOWN, ST_PWRUP};
         mod_clk_en_o <= state_q != ST_PDOWN;
         analog_on_o  <= state_q != ST_PDOWN;
         xtal_on_o    <= (state_q != ST_PDOWN) | xtal_sel_q;
         bridge_sw_o  <= bridge_q;
         in_short_o   <= (state_q == ST_CAL) & (mode_q == MODE_IZERO);
         in_fsref_o   <= (state_q == ST_CAL) & (mode_q == MODE_IFULL);
      end
   end

   // ==========================================================
   // serial clock sampling and result shifter
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sclk_s1_q <= 1'b1;
         sclk_s2_q <= 1'b1;
         sclk_s3_q <= 1'b1;
      end
      else
      begin
         sclk_s1_q <= sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
      end
   end

   // data changes on the falling serial edge so the host samples just before the next falling edge
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sh_q     <= 24'h00_0000;
         sh_cnt_q <= 5'h00;
      end
      else if (conv_done & continuous_read_enable_q)
      begin
         sh_q     <= sample_i;
         sh_cnt_q <= SHIFT_BITS;
      end
      else if (rd_req & ~continuous_read_enable_q)
      begin
         sh_q     <= data_q;
         sh_cnt_q <= SHIFT_BITS;
      end
      else if (shifting & sclk_fall)
      begin
         sh_q     <= {sh_q[22:0], 1'b0};
         sh_cnt_q <= sh_cnt_q - 5'h01;
      end
   end

   // the pin shows ready between frames and data during a frame;
   // a new load restarts the frame, so it must beat the running shift
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         dout_q <= 1'b1;
      else if (conv_done & continuous_read_enable_q)
         dout_q <= sample_i[23];
      else if (rd_req & ~continuous_read_enable_q)
         dout_q <= data_q[23];
      else if (shifting & ~shift_end)
         dout_q <= (sclk_fall) ? sh_q[22] : sh_q[23];
      else
         dout_q <= rdy_n_q;
   end

   assign dout_rdy_o = dout_q;

   // ==========================================================
   // software registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         continuous_read_enable_q <= 1'b0;
         chan_q     <= CH_RST;
         xtal_sel_q <= 1'b0;
         bridge_q   <= 1'b0;
         settle_q   <= SETTLE_RST;
         period_q   <= PERIOD_RST;
         irq_en_q   <= 2'h0;
      end
      else if (wr)
      begin
         if (hit(wb_adr_i, ADR_CTRL) & wb_sel_i[0])
            continuous_read_enable_q <= wb_dat_i[CTRL_CONT_RD_EN];
         if (hit(wb_adr_i, ADR_CTRL) & wb_sel_i[1])
            chan_q <= wb_dat_i[CTRL_CH_LSB +: 8];
         if (hit(wb_adr_i, ADR_CTRL) & wb_sel_i[2])
         begin
            xtal_sel_q <= wb_dat_i[CTRL_XTAL];
            bridge_q   <= wb_dat_i[CTRL_BRIDGE];
         end
         if (hit(wb_adr_i, ADR_SETTLE) & (&wb_sel_i[2:0]))
            settle_q <= wb_dat_i[23:0];
         if (hit(wb_adr_i, ADR_PERIOD) & (&wb_sel_i[2:0]))
            period_q <= wb_dat_i[23:0];
         if (hit(wb_adr_i, ADR_IRQ_EN) & wb_sel_i[0])
            irq_en_q <= wb_dat_i[1:0];
      end
   end

   // sticky events: a new event wins over a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         irq_st_q <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == IRQ_CONV) ? conv_done : cal_done)
               irq_st_q[i] <= 1'b1;
            else if (wr & wb_sel_i[0] & hit(wb_adr_i, ADR_IRQ_CLR) & wb_dat_i[i])
               irq_st_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_st_q & irq_en_q);
   end

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         ack_q <= 1'b0;
      else
         ack_q <= acc & ~ack_q;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rdat_q <= 32'h0000_0000;
      else if (acc & ~ack_q)
      begin
         rdat_q <= 32'h0000_0000;
         if (hit(wb_adr_i, ADR_MODE))
            rdat_q[2:0] <= mode_q;
         else if (hit(wb_adr_i, ADR_CTRL))
            rdat_q <= {14'h0000, bridge_q, xtal_sel_q, chan_q, 7'h00, continuous_read_enable_q};
         else if (hit(wb_adr_i, ADR_STATUS))
         begin
            rdat_q[ST_RDY_N]                <= rdy_n_q;
            rdat_q[ST_SHIFT]                <= shifting;
            rdat_q[ST_STATE_LSB +: 6]       <= state_q;
            rdat_q[ST_MODE_LSB +: 3]        <= mode_q;
         end
         else if (hit(wb_adr_i, ADR_DATA))
            rdat_q[23:0] <= data_q;
         else if (hit(wb_adr_i, ADR_SETTLE))
            rdat_q[23:0] <= settle_q;
         else if (hit(wb_adr_i, ADR_PERIOD))
            rdat_q[23:0] <= period_q;
         else if (hit(wb_adr_i, ADR_IRQ_STAT))
            rdat_q[1:0] <= irq_st_q;
         else if (hit(wb_adr_i, ADR_IRQ_EN))
            rdat_q[1:0] <= irq_en_q;
         else if (wb_adr_i[7:5] == WIN_OFFS)
            rdat_q[23:0] <= offs_q[wb_adr_i[4:2]];
         else if (wb_adr_i[7:5] == WIN_FULL)
            rdat_q[23:0] <= full_q[wb_adr_i[4:2]];
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_pdown_decode;
      wr_mode && wb_dat_i[2:0] == 3'h3 |=> state_q == ST_PDOWN && mode_q == MODE_PDOWN;
   endproperty
   a_pdown_decode: assert property (p_pdown_decode)
      else $error("power-down write did not enter power-down");

   property p_conv_store;
      conv_done && mode_q == MODE_CONT |=> !rdy_n_q && data_q == $past(sample_i);
   endproperty
   a_conv_store: assert property (p_conv_store)
      else $error("continuous result not stored with ready low");

   property p_cont_read_shift;
      conv_done && continuous_read_enable_q |=> shifting && dout_q == $past(sample_i[23]);
   endproperty
   a_cont_read_shift: assert property (p_cont_read_shift)
      else $error("continuous read did not start a frame");

   property p_cont_settle;
      wr_mode && wb_dat_i[2:0] == 3'h0 |=> state_q == ST_SETTLE && cnt_q == $past(settle_q);
   endproperty
   a_cont_settle: assert property (p_cont_settle)
      else $error("continuous start did not wait full settling");

   property p_single_pwrup;
      wr_mode && wb_dat_i[2:0] == 3'h1 |=> state_q == ST_PWRUP && cnt_q == PWRUP_CYC;
   endproperty
   a_single_pwrup: assert property (p_single_pwrup)
      else $error("single conversion skipped clock settle");

   property p_single_end;
      conv_done && mode_q == MODE_SINGLE |=> state_q == ST_PDOWN && !rdy_n_q ##1 !analog_on_o;
   endproperty
   a_single_end: assert property (p_single_end)
      else $error("single conversion did not power down with ready low");

   property p_idle_reset;
      state_q == ST_IDLE ##1 state_q == ST_IDLE |-> filter_rst_o && mod_rst_o && mod_clk_en_o;
   endproperty
   a_idle_reset: assert property (p_idle_reset)
      else $error("idle did not hold filter and modulator in reset");

   property p_cal_start;
      wr_mode && wb_dat_i[2] |=> rdy_n_q && state_q == ST_CAL;
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration start did not raise ready");

   property p_cal_idle;
      cal_done |=> state_q == ST_IDLE && mode_q == MODE_IDLE && !rdy_n_q && irq_st_q[IRQ_CAL];
   endproperty
   a_cal_idle: assert property (p_cal_idle)
      else $error("calibration end did not go idle");

   property p_cal_offs;
      cal_done && mode_q == MODE_IZERO |=> offs_q[$past(ch)] == $past(sample_i);
   endproperty
   a_cal_offs: assert property (p_cal_offs)
      else $error("offset coefficient not stored");

endmodule // amoc_core

// ### pkg/amoc_pkg.sv
package amoc_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] ADR_MODE     = 8'h00;
   localparam logic [7:0] ADR_CTRL     = 8'h04;
   localparam logic [7:0] ADR_STATUS   = 8'h08;
   localparam logic [7:0] ADR_DATA     = 8'h0C;
   localparam logic [7:0] ADR_CMD      = 8'h10;
   localparam logic [7:0] ADR_SETTLE   = 8'h14;
   localparam logic [7:0] ADR_PERIOD   = 8'h18;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h1C;
   localparam logic [7:0] ADR_IRQ_CLR  = 8'h20;
   localparam logic [7:0] ADR_IRQ_EN   = 8'h24;
   // coefficient windows, index in address bits 4:2
   localparam logic [2:0] WIN_OFFS     = 3'h2;
   localparam logic [2:0] WIN_FULL     = 3'h3;

   // ==========================================================
   // field positions
   localparam int CTRL_CONT_RD_EN = 0;
   localparam int CTRL_CH_LSB  = 8;
   localparam int CTRL_XTAL    = 16;
   localparam int CTRL_BRIDGE  = 17;
   localparam int CMD_RDREQ    = 0;
   localparam int IRQ_CONV     = 0;
   localparam int IRQ_CAL      = 1;
   localparam int ST_RDY_N     = 0;
   localparam int ST_SHIFT     = 1;
   localparam int ST_STATE_LSB = 8;
   localparam int ST_MODE_LSB  = 16;

   // ==========================================================
   // reset values and sizes
   localparam int          NCH          = 8;
   localparam int          DW           = 24;
   localparam logic [7:0]  CH_RST       = 8'h01;
   localparam logic [23:0] SETTLE_RST   = 24'h00_1000;
   localparam logic [23:0] PERIOD_RST   = 24'h00_0400;
   localparam logic [4:0]  SHIFT_BITS   = 5'h18;

   // ==========================================================
   // timing: clock settle in single conversion
   localparam int CLK_MHZ       = 50;
   localparam int PWRUP_US      = 1000;
   localparam int PWRUP_CYC_DEF = PWRUP_US * CLK_MHZ;

   // ==========================================================
   typedef enum logic [2:0] {
      MODE_CONT   = 3'h0,
      MODE_SINGLE = 3'h1,
      MODE_IDLE   = 3'h2,
      MODE_PDOWN  = 3'h3,
      MODE_IZERO  = 3'h4,
      MODE_IFULL  = 3'h5,
      MODE_SZERO  = 3'h6,
      MODE_SFULL  = 3'h7
   } amoc_mode_t;

   typedef enum logic [5:0] {
      ST_PWRUP  = 6'h01,
      ST_SETTLE = 6'h02,
      ST_CONV   = 6'h04,
      ST_IDLE   = 6'h08,
      ST_PDOWN  = 6'h10,
      ST_CAL    = 6'h20
   } amoc_state_t;

endpackage

// ### dv/amoc_host.sv
`timescale 1ns/10ps
// ==========================================================
// host side of the serial link: sclk idles high, 8 clk a bit
module amoc_host
(
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic        dout_i,
   output logic             sclk_o,
   output logic [23:0]      word_o,
   output logic             busy_o
);
   // sample just before each falling edge, the bit has had 5 clk to settle
   initial
   begin
      sclk_o = 1'b1;
      busy_o = 1'b0;
      word_o = '0;
      forever
      begin
         @(posedge clk_i);
         if (start_i)
         begin
            busy_o <= 1'b1;
            word_o <= '0;
            for (int i = 0; i < 24; i++)
            begin
               repeat (4) @(posedge clk_i);
               word_o <= {word_o[22:0], dout_i};
               sclk_o <= 1'b0;
               repeat (4) @(posedge clk_i);
               sclk_o <= 1'b1;
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule // amoc_host

// ### dv/adc_operating_mode_control_test.sv
`timescale 1ns/10ps
module adc_operating_mode_control_test
   import amoc_pkg::*;
;
   localparam int SET = 24;
   localparam int PER = 768;
   localparam int PW  = 20;

   logic clk, reset_i, cyc, stb, we, start, sclk, hbusy;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rd, lfsr;
   logic [23:0] samp, word, last_full;
   logic [31:0] dat_o;
   logic ack, dout, irq, frst, mrst, mclk, aon, xon, brg, shrt, fsr;
   int n_errors, num_checks, n;
   logic [7:0] mask;
   logic [2:0] slot;

   amoc_core #(.PWRUP_CYC(24'h00_0014)) uut (
      .clk_i(clk), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .sample_i(samp), .sclk_i(sclk),
      .dout_rdy_o(dout), .irq_o(irq), .filter_rst_o(frst), .mod_rst_o(mrst),
      .mod_clk_en_o(mclk), .analog_on_o(aon), .xtal_on_o(xon),
      .bridge_sw_o(brg), .in_short_o(shrt), .in_fsref_o(fsr));

   amoc_host host (.clk_i(clk), .start_i(start), .dout_i(dout),
      .sclk_o(sclk), .word_o(word), .busy_o(hbusy));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [2:0] low_bit(input logic [7:0] m);
      for (int i = 7; i >= 0; i--)
         if (m[i]) low_bit = 3'(i);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_errors++;
         conclude();
      end
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic wait_for(input int what, input int lim);
      logic hit;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         hit = (what == 0) ? (dout === 1'b0) : (what == 1) ? (irq === 1'b1)
               : (hbusy === 1'b0);
      end while (!hit && n < lim);
      if (!hit)
      begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic new_sample();
      lfsr = lfsr_next(lfsr);
      samp <= lfsr[23:0];
      @(posedge clk);
   endtask

   task automatic host_read();
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_for(2, 400);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      n_errors = 0; num_checks = 0; lfsr = 32'h6447_9710;
      reset_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = '0; sel = '0; wdat = '0;
      start = 1'b0; samp = lfsr[23:0];
      repeat (3) @(posedge clk);
      reset_i <= 1'b0;
      wait_for(0, 5000);
      chk(32'(n >= 4096 && n <= 4100), 32'h1);
      chk(32'(frst), 32'h0);
      wb(0, ADR_DATA, '0);
      chk(rd, {8'h00, samp});
      wb(0, ADR_MODE, '0);
      chk(rd, 32'h0000_0000);
      wb(0, ADR_CTRL, '0);
      chk(rd, 32'h0000_0100);
      wb(0, ADR_SETTLE, '0);
      chk(rd, 32'h0000_1000);
      wb(0, ADR_PERIOD, '0);
      chk(rd, 32'h0000_0400);
      wb(0, 8'h30, '0);
      chk(rd, 32'h0000_0000);
      $display("test reset done");

      new_sample();
      wb(1, ADR_SETTLE, 32'(SET));
      wb(1, ADR_PERIOD, 32'(PER));
      wb(1, ADR_MODE, 32'h0000_0000);
      wait_for(0, 100);
      chk(32'(n >= SET - 2 && n <= SET + 4), 32'h1);
      wb(1, ADR_CMD, 32'h0000_0001);
      host_read();
      chk({8'h00, word}, {8'h00, samp});
      chk(32'(dout), 32'h1);
      $display("test read request done");

      new_sample();
      wb(1, ADR_CTRL, 32'h0000_0101);
      wb(1, ADR_IRQ_CLR, 32'h0000_0003);
      wb(1, ADR_IRQ_EN, 32'h0000_0001);
      wait_for(1, 2 * PER);
      host_read();
      chk({8'h00, word}, {8'h00, samp});
      wb(1, ADR_IRQ_EN, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      wb(1, ADR_MODE, 32'(MODE_IDLE));
      repeat (3) @(posedge clk);
      chk({29'h0, frst, mrst, mclk}, 32'h0000_0007);
      wb(0, ADR_IRQ_STAT, '0);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      wb(1, ADR_IRQ_CLR, 32'h0000_0003);
      wb(0, ADR_IRQ_STAT, '0);
      chk(rd, 32'h0000_0000);
      $display("test continuous read done");

      wb(0, ADR_DATA, '0);
      wb(1, ADR_CTRL, 32'h0003_0100);
      new_sample();
      wb(1, ADR_MODE, 32'(MODE_SINGLE));
      wait_for(0, 200);
      chk(32'(n >= PW + SET && n <= PW + SET + 5), 32'h1);
      wb(0, ADR_MODE, '0);
      chk(rd, 32'(MODE_PDOWN));
      chk({28'h0, aon, mclk, xon, brg}, 32'h0000_0003);
      wb(1, ADR_CTRL, 32'h0002_0100);
      repeat (2) @(posedge clk);
      chk({28'h0, aon, mclk, xon, brg}, 32'h0000_0001);
      repeat (30) @(posedge clk);
      chk(32'(dout), 32'h0);
      wb(0, ADR_DATA, '0);
      chk(rd, {8'h00, samp});
      repeat (2) @(posedge clk);
      chk(32'(dout), 32'h1);
      $display("test single done");

      for (int m = 4; m < 8; m++)
      begin
         lfsr = lfsr_next(lfsr);
         mask = (lfsr[31:24] == 0) ? 8'h80 : lfsr[31:24];
         slot = low_bit(mask);
         wb(1, ADR_CTRL, {16'h0, mask, 8'h00});
         new_sample();
         wb(1, ADR_MODE, 32'(m));
         repeat (2) @(posedge clk);
         chk(32'(dout), 32'h1);
         chk({30'h0, shrt, fsr}, 32'((m == 4) ? 2 : (m == 5) ? 1 : 0));
         wait_for(0, SET + 10);
         wb(0, ADR_MODE, '0);
         chk(rd, 32'(MODE_IDLE));
         wb(0, (m[0] ? 8'h60 : 8'h40) + {3'h0, slot, 2'h0}, '0);
         chk(rd, {8'h00, samp});
         last_full = samp;
      end
      $display("test calibration done");

      new_sample();
      wb(1, ADR_MODE, 32'(MODE_IFULL));
      repeat (5) @(posedge clk);
      wb(1, ADR_MODE, 32'(MODE_IDLE));
      repeat (SET + 20) @(posedge clk);
      chk(32'(dout), 32'h1);
      wb(0, 8'h60 + {3'h0, slot, 2'h0}, '0);
      chk(rd, {8'h00, last_full});
      $display("test abandon done");
      conclude();
   end
endmodule // adc_operating_mode_control_test
